/* File: logic/sbr_pkg.sv */
// package: register map, field layout and reset values of the serial port register block
package sbr_pkg;
    localparam logic [7:0] ADDR_RELOAD = 8'h91;
    localparam logic [7:0] ADDR_CONTROL = 8'h92;
    localparam logic [7:0] ADDR_BUFFER = 8'h99;
    localparam logic [7:0] ADDR_SLAVE = 8'hA9;
    localparam logic [7:0] ADDR_MASK = 8'hB9;
    localparam int BIT_RUN = 4;
    localparam int BIT_TX_SEL = 3;
    localparam int BIT_RX_SEL = 2;
    localparam int BIT_SPEED = 1;
    localparam int BIT_SYNC_SRC = 0;
    localparam logic [7:0] CONTROL_DEFINED = 8'h1F;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    // low speed divides the generator tick by this extra factor
    localparam logic [7:0] SLOW_DIVIDE = 8'h02;
endpackage

/* File: logic/sbr_skid_buffer.sv */
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module sbr_skid_buffer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic rd_q;
    logic wr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    full_never_push_a: assert property (@(posedge clock) disable iff (srst)
        count_q == 2'h2 |-> !in_ready) else $error("buffer accepts when full");
endmodule

/* File: logic/sbr_regs.sv */
// serial port registers: data buffer, address recognition, baud generator
`timescale 1ns/1ps
// Operation
// - reading buffer returns last received byte (code does not store address bytes that miss in multiprocessor mode)
// - writing buffer queues byte for transmitter
// - buffer content undefined after reset
// - slave address register, reset zero
// - address mask register, reset zero
// - run bit starts and stops generator
// - speed bit selects high or low rate
// - reserved control bits indeterminate, never set
// - reload register holds generator reload value
// - mask zero bits are don't-care
// - broadcast is address OR mask
// - multiprocessor mode flags only matching addresses
module sbr_regs #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // transmitter data path
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_write_stall,
    // receiver side
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_is_address,
    input wire logic multiprocessor_enable,
    output logic receive_flag_set,
    // baud clocks
    input wire logic timer_tx_tick,
    input wire logic timer_rx_tick,
    output logic tx_baud_tick,
    output logic rx_baud_tick,
    output logic sync_mode_tick
);
    logic [7:0] baud_reload_value_q;
    logic [7:0] baud_generator_control_q;
    logic [7:0] serial_data_buffer_q;
    logic [7:0] individual_slave_address_q;
    logic [7:0] slave_address_mask_q;
    logic [7:0] gen_count_q;
    logic [7:0] slow_count_q;
    logic gen_tick;
    logic baud_tick;
    logic flag_q;
    logic buf_in_ready;
    logic buf_write;
    logic addr_hit;
    logic baud_run;
    logic baud_speed_select;
    logic tx_clock_source_select;
    logic rx_clock_source_select;
    logic sync_mode_clock_source;

    // masked compare: pattern bits count only where the mask is one
    function automatic logic masked_match(input logic [7:0] value, input logic [7:0] pattern,
                                          input logic [7:0] mask);
        masked_match = ((value ^ pattern) & mask) == sbr_pkg::RESET_ZERO;
    endfunction

    assign baud_run = baud_generator_control_q[sbr_pkg::BIT_RUN];
    assign baud_speed_select = baud_generator_control_q[sbr_pkg::BIT_SPEED];
    assign tx_clock_source_select = baud_generator_control_q[sbr_pkg::BIT_TX_SEL];
    assign rx_clock_source_select = baud_generator_control_q[sbr_pkg::BIT_RX_SEL];
    assign sync_mode_clock_source = baud_generator_control_q[sbr_pkg::BIT_SYNC_SRC];

    assign buf_write = sfr_wr && (sfr_addr == sbr_pkg::ADDR_BUFFER);
    assign tx_write_stall = !buf_in_ready;

    sbr_skid_buffer #(.WIDTH(WIDTH)) u_tx_buf (
        .clock(clock),
        .srst(srst),
        .in_valid(buf_write),
        .in_ready(buf_in_ready),
        .in_data(sfr_wdata),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            baud_reload_value_q <= sbr_pkg::RESET_ZERO;
            individual_slave_address_q <= sbr_pkg::RESET_ZERO;
            slave_address_mask_q <= sbr_pkg::RESET_ZERO;
        end else if (sfr_wr) begin
            if (sfr_addr == sbr_pkg::ADDR_RELOAD) begin
                baud_reload_value_q <= sfr_wdata;
            end
            if (sfr_addr == sbr_pkg::ADDR_SLAVE) begin
                individual_slave_address_q <= sfr_wdata;
            end
            if (sfr_addr == sbr_pkg::ADDR_MASK) begin
                slave_address_mask_q <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            baud_generator_control_q <= sbr_pkg::RESET_ZERO;
        end else if (sfr_wr && sfr_addr == sbr_pkg::ADDR_CONTROL) begin
            baud_generator_control_q <= sfr_wdata & sbr_pkg::CONTROL_DEFINED;
        end
    end

    assign addr_hit = masked_match(rx_byte, individual_slave_address_q, slave_address_mask_q)
        || masked_match(rx_byte, individual_slave_address_q | slave_address_mask_q,
                        individual_slave_address_q | slave_address_mask_q);

    // last received byte except non-matching addresses in multiprocessor mode, no reset on purpose
    always_ff @(posedge clock) begin
        if (rx_byte_valid && (!multiprocessor_enable || !rx_is_address || addr_hit)) begin
            serial_data_buffer_q <= rx_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= rx_byte_valid
                && (!multiprocessor_enable || (rx_is_address && addr_hit));
        end
    end
    assign receive_flag_set = flag_q;

    always_ff @(posedge clock) begin
        if (srst || !baud_run) begin
            gen_count_q <= sbr_pkg::RESET_ZERO;
        end else if (gen_count_q == sbr_pkg::ALL_ONES) begin
            gen_count_q <= baud_reload_value_q;
        end else begin
            gen_count_q <= gen_count_q + 8'h01;
        end
    end
    assign gen_tick = baud_run && (gen_count_q == sbr_pkg::ALL_ONES);

    // low speed divides the overflow further
    always_ff @(posedge clock) begin
        if (srst || !baud_run) begin
            slow_count_q <= sbr_pkg::RESET_ZERO;
        end else if (gen_tick) begin
            if (slow_count_q == sbr_pkg::SLOW_DIVIDE - 8'h01) begin
                slow_count_q <= sbr_pkg::RESET_ZERO;
            end else begin
                slow_count_q <= slow_count_q + 8'h01;
            end
        end
    end
    assign baud_tick = gen_tick
        && (baud_speed_select || slow_count_q == sbr_pkg::SLOW_DIVIDE - 8'h01);

    assign tx_baud_tick = tx_clock_source_select ? baud_tick : timer_tx_tick;
    assign rx_baud_tick = rx_clock_source_select ? baud_tick : timer_rx_tick;
    assign sync_mode_tick = sync_mode_clock_source && baud_tick;

    always_comb begin
        sfr_rdata = sbr_pkg::RESET_ZERO;
        if (sfr_rd) begin
            unique case (sfr_addr)
                sbr_pkg::ADDR_RELOAD: sfr_rdata = baud_reload_value_q;
                sbr_pkg::ADDR_CONTROL: sfr_rdata = baud_generator_control_q;
                sbr_pkg::ADDR_BUFFER: sfr_rdata = serial_data_buffer_q;
                sbr_pkg::ADDR_SLAVE: sfr_rdata = individual_slave_address_q;
                sbr_pkg::ADDR_MASK: sfr_rdata = slave_address_mask_q;
                default: sfr_rdata = sbr_pkg::RESET_ZERO;
            endcase
        end
    end

    reserved_bits_zero_a: assert property (@(posedge clock) disable iff (srst)
        (baud_generator_control_q & ~sbr_pkg::CONTROL_DEFINED) == sbr_pkg::RESET_ZERO)
        else $error("reserved control bits set");
    stopped_no_tick_a: assert property (@(posedge clock) disable iff (srst)
        !baud_run |-> !gen_tick) else $error("tick while stopped");
    slow_half_rate_a: assert property (@(posedge clock) disable iff (srst)
        baud_tick && !baud_speed_select |-> slow_count_q == sbr_pkg::SLOW_DIVIDE - 8'h01)
        else $error("low speed tick early");
    tx_source_sel_a: assert property (@(posedge clock) disable iff (srst)
        !tx_clock_source_select |-> tx_baud_tick == timer_tx_tick)
        else $error("tx source wrong");
    sync_src_off_a: assert property (@(posedge clock) disable iff (srst)
        !sync_mode_clock_source |-> !sync_mode_tick) else $error("mode zero tick");
    flag_match_a: assert property (@(posedge clock) disable iff (srst)
        rx_byte_valid && multiprocessor_enable && !addr_hit |=> !receive_flag_set)
        else $error("flag on foreign address");
    buffer_read_a: assert property (@(posedge clock) disable iff (srst)
        rx_byte_valid && !multiprocessor_enable ##1 !rx_byte_valid ##1 sfr_rd
        && sfr_addr == sbr_pkg::ADDR_BUFFER && !rx_byte_valid
        |-> sfr_rdata == $past(rx_byte, 2)) else $error("buffer read stale");
    slave_reset_a: assert property (@(posedge clock)
        $past(srst) |-> individual_slave_address_q == sbr_pkg::RESET_ZERO
        && slave_address_mask_q == sbr_pkg::RESET_ZERO) else $error("address reset");
    reload_write_a: assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == sbr_pkg::ADDR_RELOAD |=> baud_reload_value_q == $past(sfr_wdata))
        else $error("reload not written");
    tx_queue_a: assert property (@(posedge clock) disable iff (srst)
        buf_write && buf_in_ready |=> tx_valid) else $error("write not queued");

    rx_source_sel_a: assert property (@(posedge clock) disable iff (srst)
        !rx_clock_source_select |-> rx_baud_tick == timer_rx_tick)
        else $error("rx source wrong");
    rx_source_gen_a: assert property (@(posedge clock) disable iff (srst)
        rx_clock_source_select |-> rx_baud_tick == baud_tick)
        else $error("rx generator source wrong");
    tx_source_gen_a: assert property (@(posedge clock) disable iff (srst)
        tx_clock_source_select |-> tx_baud_tick == baud_tick)
        else $error("tx generator source wrong");
    sync_src_on_a: assert property (@(posedge clock) disable iff (srst)
        sync_mode_clock_source && baud_tick |-> sync_mode_tick)
        else $error("mode zero tick missing");

    fast_every_tick_a: assert property (@(posedge clock) disable iff (srst)
        gen_tick && baud_speed_select |-> baud_tick)
        else $error("high speed tick missing");
    gen_reload_a: assert property (@(posedge clock) disable iff (srst)
        baud_run && gen_count_q == sbr_pkg::ALL_ONES
        && !(sfr_wr && sfr_addr == sbr_pkg::ADDR_CONTROL)
        |=> gen_count_q == $past(baud_reload_value_q)) else $error("generator not reloaded");
    gen_step_a: assert property (@(posedge clock) disable iff (srst)
        baud_run && gen_count_q != sbr_pkg::ALL_ONES
        && !(sfr_wr && sfr_addr == sbr_pkg::ADDR_CONTROL)
        |=> gen_count_q == $past(gen_count_q) + 8'h01) else $error("generator not counting");
    stopped_clear_a: assert property (@(posedge clock) disable iff (srst)
        !baud_run |=> gen_count_q == sbr_pkg::RESET_ZERO)
        else $error("generator not cleared");

    control_write_a: assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == sbr_pkg::ADDR_CONTROL
        |=> baud_generator_control_q == ($past(sfr_wdata) & sbr_pkg::CONTROL_DEFINED))
        else $error("control not written");
    slave_write_a: assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == sbr_pkg::ADDR_SLAVE
        |=> individual_slave_address_q == $past(sfr_wdata)) else $error("address not written");
    mask_write_a: assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == sbr_pkg::ADDR_MASK
        |=> slave_address_mask_q == $past(sfr_wdata)) else $error("mask not written");
    rdata_idle_a: assert property (@(posedge clock) disable iff (srst)
        !sfr_rd |-> sfr_rdata == sbr_pkg::RESET_ZERO) else $error("read data without read");

    flag_pulse_a: assert property (@(posedge clock) disable iff (srst)
        !rx_byte_valid |=> !receive_flag_set) else $error("flag without frame");
    flag_plain_a: assert property (@(posedge clock) disable iff (srst)
        rx_byte_valid && !multiprocessor_enable |=> receive_flag_set)
        else $error("flag missing");
    buffer_store_a: assert property (@(posedge clock) disable iff (srst)
        rx_byte_valid && !multiprocessor_enable |=> serial_data_buffer_q == $past(rx_byte))
        else $error("byte not stored");
    foreign_kept_a: assert property (@(posedge clock) disable iff (srst)
        rx_byte_valid && multiprocessor_enable && rx_is_address && !addr_hit
        |=> serial_data_buffer_q == $past(serial_data_buffer_q))
        else $error("foreign address stored");

    cov_tick_c: cover property (@(posedge clock) disable iff (srst) baud_tick);
    cov_match_c: cover property (@(posedge clock) disable iff (srst) receive_flag_set);
    cov_stall_c: cover property (@(posedge clock) disable iff (srst) tx_write_stall);
    cov_slow_c: cover property (@(posedge clock) disable iff (srst)
        baud_tick && !baud_speed_select);
    cov_drain_c: cover property (@(posedge clock) disable iff (srst) tx_valid && tx_ready);
endmodule

/* File: sim/sbr_remote_model.sv */
// remote serial station model: takes transmit bytes and sends received frames
`timescale 1ns/1ps
module sbr_remote_model (
    // clock
    input wire logic clock,
    // transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // receive side
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_is_address
);
    logic stall = 1'b1;
    logic [7:0] got_q[$];
    initial begin
        tx_ready = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_is_address = 1'b0;
    end
    always @(negedge clock) begin
        tx_ready <= ~stall;
    end
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_data);
        end
    end
    // one frame; lines show the inverse once it is done
    task send(input logic [7:0] b, input logic a);
        @(negedge clock);
        rx_byte_valid = 1'b1;
        rx_byte = b;
        rx_is_address = a;
        @(negedge clock);
        rx_byte_valid = 1'b0;
        rx_byte = ~b;
        rx_is_address = ~a;
    endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the serial port register block
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, tx_data, rx_byte;
    logic tx_valid, tx_ready, tx_write_stall, rx_byte_valid, rx_is_address, receive_flag_set;
    logic multiprocessor_enable = 1'b0;
    logic timer_tx_tick = 1'b0;
    logic timer_rx_tick = 1'b0;
    logic tx_baud_tick, rx_baud_tick, sync_mode_tick;
    int num_errors = 0;
    int comparisons = 0;
    logic [9:0] tab [0:5] = '{10'h355, 10'h357, 10'h15A, 10'h3FE, 10'h112, 10'h055};
    always #12.5 clock = ~clock;
    sbr_regs dut (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_write_stall(tx_write_stall),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_is_address(rx_is_address),
        .multiprocessor_enable(multiprocessor_enable), .receive_flag_set(receive_flag_set),
        .timer_tx_tick(timer_tx_tick), .timer_rx_tick(timer_rx_tick),
        .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick),
        .sync_mode_tick(sync_mode_tick));
    sbr_remote_model model (.clock(clock), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_is_address(rx_is_address));
    task test_done;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(posedge clock);
        chk(sfr_rdata, exp);
        @(negedge clock);
        sfr_rd = 1'b0;
    endtask
    task reg_access;
        // registers come up zero, unmapped reads zero
        rchk(8'h91, 8'h00);
        rchk(8'h92, 8'h00);
        rchk(8'hA9, 8'h00);
        rchk(8'hB9, 8'h00);
        rchk(8'h93, 8'h00);
        wr(8'h91, 8'hA5);
        rchk(8'h91, 8'hA5);
        wr(8'hA9, 8'h5A);
        rchk(8'hA9, 8'h5A);
        wr(8'hB9, 8'hC3);
        rchk(8'hB9, 8'hC3);
        wr(8'h92, 8'hFF);
        rchk(8'h92, 8'h1F);
    endtask
    task tx_path;
        wr(8'h99, 8'h11);
        wr(8'h99, 8'h22);
        chk(tx_write_stall, 8'h01);
        wr(8'h99, 8'h33);
        model.stall = 1'b0;
        repeat (6) @(negedge clock);
        chk(model.got_q.size(), 8'h02);
        chk(model.got_q[0], 8'h11);
        chk(model.got_q[1], 8'h22);
        chk(tx_valid, 8'h00);
    endtask
    task rx_path;
        model.send(8'h3C, 1'b0);
        chk(receive_flag_set, 8'h01);
        rchk(8'h99, 8'h3C);
        wr(8'hA9, 8'h56);
        wr(8'hB9, 8'hFC);
        multiprocessor_enable = 1'b1;
        for (int i = 0; i < 6; i++) begin
            model.send(tab[i][7:0], tab[i][8]);
            chk(receive_flag_set, {7'h00, tab[i][9]});
        end
        multiprocessor_enable = 1'b0;
    endtask
    task period(input int exp);
        int n;
        n = 0;
        while (tx_baud_tick !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > 600) begin
                num_errors++;
                $display("[FAIL] %0t no baud tick", $time);
                test_done();
            end
        end
        chk(rx_baud_tick, 8'h01);
        chk(sync_mode_tick, 8'h01);
        n = 1;
        @(negedge clock);
        while (tx_baud_tick !== 1'b1 && n < 600) begin
            @(negedge clock);
            n++;
        end
        chk(n[7:0], exp[7:0]);
    endtask
    task baud;
        wr(8'h91, 8'hFC);
        wr(8'h92, 8'h1F);
        period(4);
        wr(8'h92, 8'h1D);
        period(8);
        wr(8'h92, 8'h10);
        @(negedge clock);
        timer_tx_tick = 1'b1;
        #1 chk(tx_baud_tick, 8'h01);
        chk(rx_baud_tick, 8'h00);
        @(negedge clock);
        timer_tx_tick = 1'b0;
        wr(8'h92, 8'h0F);
        repeat (300) begin
            @(negedge clock);
            chk(tx_baud_tick, 8'h00);
        end
    endtask
    initial begin
        repeat (5) @(negedge clock);
        srst = 1'b0;
        reg_access();
        tx_path();
        rx_path();
        baud();
        test_done();
    end
endmodule
